/* rtl/fvc_consts.svh */
`ifndef FVC_CONSTS_SVH
`define FVC_CONSTS_SVH
// Command opcodes
`define FVC_OP_READ_CFG1 8'h35
`define FVC_OP_VOL_WREN 8'h50
`define FVC_OP_WRITE_REGS 8'h01
`define FVC_OP_WRITE_ANY 8'h71
`define FVC_OP_READ_ANY 8'h65
`define FVC_OP_QI_ENTER 8'h38
`define FVC_OP_QI_EXIT 8'hF5
`define FVC_OP_SOFT_RESET 8'h99
// Register addresses for the any-register commands
`define FVC_A_CFG1_NV 24'h000002
`define FVC_A_CFG2_NV 24'h000003
`define FVC_A_CFG1_V 24'h800002
`define FVC_A_CFG2_V 24'h800003
// Field positions
`define FVC_B_HALTED 7
`define FVC_B_INVERT 6
`define FVC_B_LOCK_HI 5
`define FVC_B_LOCK_LO 2
`define FVC_B_WIDTH4 1
`define FVC_B_REGLOCK 0
`define FVC_B_QI_MODE 3
`define FVC_B_IO3_RST 7
// Timing
`define FVC_CLK_NS 100
`define FVC_QUAD_ENTRY_NS 1000
`define FVC_QUAD_EXIT_NS 1000
`endif

/* rtl/fvc_pkg.sv */
package fvc_pkg;
    typedef enum logic [2:0] {
        FVC_IDLE = 3'h0,
        FVC_OPCODE = 3'h1,
        FVC_ADDR = 3'h3,
        FVC_WRITE = 3'h2,
        FVC_READ = 3'h6,
        FVC_DONE = 3'h7
    } fvc_state_t;
endpackage

/* rtl/fvc_cfg1_top.sv */
`include "fvc_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module fvc_cfg1_top (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic sck_i,
    input wire logic csn_i,
    input wire logic si_i,
    input wire logic wp_n_i,
    input wire logic io3_rst_n_i,
    input wire logic suspended_i,
    input wire logic [3:0] otp_lock_i,
    input wire logic [7:0] nv_cfg1_i,
    input wire logic [7:0] nv_cfg2_i,
    input wire logic pin_gated_protect_i,
    output logic so_o,
    output logic so_oe_n_o,
    output logic [7:0] cfg1_o,
    output logic [7:0] cfg2_o,
    output logic width4_active_o,
    output logic io2_data_sel_o,
    output logic io3_data_sel_o,
    output logic wp_n_eff_o,
    output logic invert_map_o,
    output logic hw_reset_o,
    output logic write_reject_o
);
    localparam int QEN_RAW = `FVC_QUAD_ENTRY_NS / `FVC_CLK_NS;
    localparam int QEX_RAW = `FVC_QUAD_EXIT_NS / `FVC_CLK_NS;
    localparam int QEN_CYC = (QEN_RAW < 1) ? 1 : QEN_RAW;
    localparam int QEX_CYC = (QEX_RAW < 1) ? 1 : QEX_RAW;
    localparam int QWAIT = ((QEN_CYC > QEX_CYC) ? QEN_CYC : QEX_CYC) + 2;

    logic [1:0] rs_q;
    logic rst_n;
    logic [2:0] sck_s_q, csn_s_q;
    logic [1:0] si_s_q, wp_s_q, io3_s_q;
    logic init_q, hw_rst_q;
    fvc_pkg::fvc_state_t st_q;
    logic [4:0] cnt_q;
    logic [7:0] sh_q, op_q;
    logic [23:0] addr_q;
    logic [1:0] nb_q;
    logic [7:0] w1_q, w2_q;
    logic [2:0] rcnt_q;
    logic halted_q, invert_q, width4_q, reglock_q, wel_q, act_q;
    logic [3:0] lockc_q;
    logic [7:0] volatile_config_two_q;
    logic [7:0] qcnt_q;
    logic so_q, so_oe_n_q, io2_q, io3_q, wp_eff_q, rej_q;

    // Reset release through two flops
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rs_q <= 2'h0;
        end else begin
            rs_q <= {rs_q[0], 1'b1};
        end
    end
    assign rst_n = rs_q[1];

    // Pin synchronisers; stage 0 only feeds stage 1
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sck_s_q <= 3'h0;
            csn_s_q <= 3'h7;
            si_s_q <= 2'h0;
            wp_s_q <= 2'h3;
            io3_s_q <= 2'h3;
        end else begin
            sck_s_q <= {sck_s_q[1:0], sck_i};
            csn_s_q <= {csn_s_q[1:0], csn_i};
            si_s_q <= {si_s_q[0], si_i};
            wp_s_q <= {wp_s_q[0], wp_n_i};
            io3_s_q <= {io3_s_q[0], io3_rst_n_i};
        end
    end

    logic sck_rise, sck_fall, cs_rise, active, si_b;
    assign sck_rise = sck_s_q[1] & ~sck_s_q[2];
    assign sck_fall = ~sck_s_q[1] & sck_s_q[2];
    assign cs_rise = csn_s_q[1] & ~csn_s_q[2];
    assign active = ~csn_s_q[1];
    assign si_b = si_s_q[1];

    logic [7:0] sh_d;
    assign sh_d = {sh_q[6:0], si_b};

    // Readable register mux
    function automatic logic [7:0] rd_sel(input logic [7:0] op, input logic [23:0] a,
                                          input logic [7:0] c1, input logic [7:0] c2,
                                          input logic [7:0] n1, input logic [7:0] n2);
        logic [7:0] r;
        r = 8'h00;
        if (op == `FVC_OP_READ_CFG1) begin
            r = c1;
        end else if (a == `FVC_A_CFG1_V) begin
            r = c1;
        end else if (a == `FVC_A_CFG2_V) begin
            r = c2;
        end else if (a == `FVC_A_CFG1_NV) begin
            r = n1;
        end else if (a == `FVC_A_CFG2_NV) begin
            r = n2;
        end
        return r;
    endfunction

    logic [7:0] cfg1_w, rd_byte;
    assign cfg1_w = {halted_q, invert_q, lockc_q, width4_q, reglock_q};
    assign rd_byte = rd_sel(op_q, addr_q, cfg1_w, volatile_config_two_q, nv_cfg1_i, nv_cfg2_i);

    // Command framing on the serial clock edges
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= fvc_pkg::FVC_IDLE;
            cnt_q <= 5'h00;
            sh_q <= 8'h00;
            op_q <= 8'h00;
            addr_q <= 24'h000000;
            nb_q <= 2'h0;
            w1_q <= 8'h00;
            w2_q <= 8'h00;
        end else if (!active) begin
            st_q <= fvc_pkg::FVC_IDLE;
            cnt_q <= 5'h00;
        end else if (st_q == fvc_pkg::FVC_IDLE) begin
            st_q <= fvc_pkg::FVC_OPCODE;
            cnt_q <= 5'h00;
            nb_q <= 2'h0;
        end else if (sck_rise) begin
            sh_q <= sh_d;
            cnt_q <= cnt_q + 5'h01;
            unique case (st_q)
                fvc_pkg::FVC_OPCODE: begin
                    if (cnt_q == 5'h07) begin
                        op_q <= sh_d;
                        cnt_q <= 5'h00;
                        unique case (sh_d)
                            `FVC_OP_READ_CFG1: st_q <= fvc_pkg::FVC_READ;
                            `FVC_OP_READ_ANY, `FVC_OP_WRITE_ANY: st_q <= fvc_pkg::FVC_ADDR;
                            `FVC_OP_WRITE_REGS: st_q <= fvc_pkg::FVC_WRITE;
                            default: st_q <= fvc_pkg::FVC_DONE;
                        endcase
                    end
                end
                fvc_pkg::FVC_ADDR: begin
                    addr_q <= {addr_q[22:0], si_b};
                    if (cnt_q == 5'h17) begin
                        cnt_q <= 5'h00;
                        st_q <= (op_q == `FVC_OP_READ_ANY) ? fvc_pkg::FVC_READ
                                                           : fvc_pkg::FVC_WRITE;
                    end
                end
                fvc_pkg::FVC_WRITE: begin
                    cnt_q <= {2'h0, cnt_q[2:0] + 3'h1};
                    if (cnt_q[2:0] == 3'h7) begin
                        if (nb_q != 2'h3) begin
                            nb_q <= nb_q + 2'h1;
                        end
                        if (op_q == `FVC_OP_WRITE_ANY || nb_q == 2'h1) begin
                            w1_q <= sh_d;
                        end
                        if (op_q == `FVC_OP_WRITE_REGS && nb_q == 2'h2) begin
                            w2_q <= sh_d;
                        end
                    end
                end
                fvc_pkg::FVC_READ: begin
                end
                fvc_pkg::FVC_DONE: begin
                end
            endcase
        end
    end

    // Serial output, shifted on falling clock edges
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            so_q <= 1'b0;
            so_oe_n_q <= 1'b1;
            rcnt_q <= 3'h0;
        end else if (st_q != fvc_pkg::FVC_READ || !active) begin
            so_oe_n_q <= 1'b1;
            rcnt_q <= 3'h0;
        end else begin
            so_oe_n_q <= 1'b0;
            if (sck_fall) begin
                so_q <= rd_byte[3'h7 - rcnt_q];
                rcnt_q <= rcnt_q + 3'h1;
            end
        end
    end

    logic one_byte, wr_end, wr_ok, sw_cmd, load_all;
    assign one_byte = cs_rise & (st_q == fvc_pkg::FVC_DONE) & (cnt_q == 5'h00);
    assign wr_end = cs_rise & (st_q == fvc_pkg::FVC_WRITE) & (cnt_q[2:0] == 3'h0);
    // Lock bit rejects all; otherwise pin-gated protect with the pin
    assign wr_ok = wel_q & ~reglock_q & ~(pin_gated_protect_i & ~wp_eff_q);
    assign sw_cmd = one_byte & (op_q == `FVC_OP_SOFT_RESET);
    assign load_all = init_q | hw_rst_q;

    logic wr_c1, wr_c2;
    assign wr_c1 = wr_end & wr_ok & (op_q == `FVC_OP_WRITE_REGS ? nb_q >= 2'h2
                   : (nb_q != 2'h0 && addr_q == `FVC_A_CFG1_V));
    assign wr_c2 = wr_end & wr_ok & (op_q == `FVC_OP_WRITE_REGS ? nb_q == 2'h3
                   : (nb_q != 2'h0 && addr_q == `FVC_A_CFG2_V));

    // Power-on load marker and hardware reset via shared pin
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            init_q <= 1'b1;
            hw_rst_q <= 1'b0;
        end else begin
            init_q <= 1'b0;
            hw_rst_q <= volatile_config_two_q[`FVC_B_IO3_RST] & ~io3_s_q[1] & (csn_s_q[1] | ~act_q);
        end
    end

    // Volatile configuration one and two
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            invert_q <= 1'b0;
            width4_q <= 1'b0;
            reglock_q <= 1'b0;
            volatile_config_two_q <= 8'h00;
        end else if (load_all) begin
            invert_q <= nv_cfg1_i[`FVC_B_INVERT];
            width4_q <= nv_cfg1_i[`FVC_B_WIDTH4];
            reglock_q <= nv_cfg1_i[`FVC_B_REGLOCK];
            volatile_config_two_q <= nv_cfg2_i;
        end else if (sw_cmd) begin
            invert_q <= nv_cfg1_i[`FVC_B_INVERT];
            width4_q <= nv_cfg1_i[`FVC_B_WIDTH4];
            volatile_config_two_q <= nv_cfg2_i;
        end else begin
            if (wr_c1) begin
                invert_q <= w1_q[`FVC_B_INVERT];
                width4_q <= w1_q[`FVC_B_WIDTH4];
                reglock_q <= w1_q[`FVC_B_REGLOCK];
            end
            if (wr_c2) begin
                volatile_config_two_q <= (op_q == `FVC_OP_WRITE_ANY) ? w1_q : w2_q;
            end else if (one_byte && op_q == `FVC_OP_QI_ENTER) begin
                volatile_config_two_q[`FVC_B_QI_MODE] <= 1'b1;
            end else if (one_byte && op_q == `FVC_OP_QI_EXIT) begin
                volatile_config_two_q[`FVC_B_QI_MODE] <= 1'b0;
            end
        end
    end

    // Read-only status copies
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            halted_q <= 1'b0;
            lockc_q <= 4'h0;
        end else begin
            halted_q <= init_q ? nv_cfg1_i[`FVC_B_HALTED] : suspended_i;
            lockc_q <= otp_lock_i;
        end
    end

    // Volatile write enable and reject flag
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wel_q <= 1'b0;
            rej_q <= 1'b0;
        end else begin
            rej_q <= wr_end & ~wr_ok;
            if (load_all || sw_cmd || wr_end) begin
                wel_q <= 1'b0;
            end else if (one_byte && op_q == `FVC_OP_VOL_WREN) begin
                wel_q <= 1'b1;
            end
        end
    end

    // Data-width switch after entry or exit time
    logic want4;
    assign want4 = width4_q | volatile_config_two_q[`FVC_B_QI_MODE];
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            act_q <= 1'b0;
            qcnt_q <= 8'h00;
        end else if (load_all) begin
            act_q <= nv_cfg1_i[`FVC_B_WIDTH4] | nv_cfg2_i[`FVC_B_QI_MODE];
            qcnt_q <= 8'h00;
        end else if (want4 == act_q) begin
            qcnt_q <= 8'h00;
        end else if (qcnt_q == 8'((want4 ? QEN_CYC : QEX_CYC) - 1)) begin
            act_q <= want4;
            qcnt_q <= 8'h00;
        end else begin
            qcnt_q <= qcnt_q + 8'h01;
        end
    end

    // Pin roles; serial and dual framing never uses lines two, three
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            io2_q <= 1'b0;
            io3_q <= 1'b0;
            wp_eff_q <= 1'b1;
        end else begin
            io2_q <= act_q;
            io3_q <= act_q & active;
            wp_eff_q <= act_q | wp_s_q[1];
        end
    end

    assign so_o = so_q;
    assign so_oe_n_o = so_oe_n_q;
    assign cfg1_o = cfg1_w;
    assign cfg2_o = volatile_config_two_q;
    assign width4_active_o = act_q;
    assign io2_data_sel_o = io2_q;
    assign io3_data_sel_o = io3_q;
    assign wp_n_eff_o = wp_eff_q;
    assign invert_map_o = invert_q;
    assign hw_reset_o = hw_rst_q;
    assign write_reject_o = rej_q;

    // Checks
    a_halted_follow: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        !init_q |=> cfg1_o[7] == $past(suspended_i)) else $error("halted flag wrong");
    a_lock_copy: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        rst_n |=> cfg1_o[5:2] == $past(otp_lock_i)) else $error("lock copy stale");
    a_wp_forced: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        width4_active_o |=> wp_n_eff_o) else $error("wp not forced high");
    a_io3_data_role: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        width4_active_o && active |=> io3_data_sel_o) else $error("io3 role wrong");
    a_lock_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        reglock_q && !load_all |=> reglock_q) else $error("lock cleared");
    a_locked_no_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        reglock_q && wr_end && !load_all |=> $stable(cfg1_o[6:0]) && $stable(cfg2_o)
        && write_reject_o) else $error("write while locked");
    a_sw_keeps_lock: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        sw_cmd && !load_all |=> reglock_q == $past(reglock_q) && cfg2_o == $past(nv_cfg2_i))
        else $error("soft reset hit lock");
    a_por_defaults: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        rst_n && init_q |=> cfg1_o[0] == $past(nv_cfg1_i[0]) && cfg1_o[7] == $past(nv_cfg1_i[7])
        && cfg1_o[6] == $past(nv_cfg1_i[6]) && cfg1_o[1] == $past(nv_cfg1_i[1]))
        else $error("power-on defaults wrong");
    a_width_switch: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        want4 != width4_active_o && !load_all |-> ##[1:QWAIT]
        (width4_active_o == want4 || load_all)) else $error("width switch late");
    c_write_ok: cover property (@(posedge ref_clk_i) disable iff (!rst_n) wr_c1);
    c_lock_set: cover property (@(posedge ref_clk_i) disable iff (!rst_n) $rose(reglock_q));
    c_width_on: cover property (@(posedge ref_clk_i) disable iff (!rst_n) $rose(act_q));
    c_read_out: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
        st_q == fvc_pkg::FVC_READ && sck_fall);
endmodule
`default_nettype wire

/* tb/fvc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module fvc_host_model (
    input wire logic so_i,
    input wire logic so_oe_n_i,
    output logic sck_o,
    output logic csn_o,
    output logic si_o
);
    // Link clock stands low between frames
    initial begin
        sck_o = 1'b0;
        csn_o = 1'b1;
        si_o = 1'b0;
    end

    // One mode-0 frame, MSB first, bits right aligned; serial commands only
    task automatic frame(input int nbits, input logic [39:0] tx, output logic [39:0] rx);
        rx = '0;
        #137;
        csn_o = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            si_o = tx[i];
            #400;
            sck_o = 1'b1;
            #399;
            rx[i] = (so_oe_n_i === 1'b0) ? so_i : 1'bx; // Late in high phase
            #1;
            sck_o = 1'b0;
        end
        #400;
        csn_o = 1'b1;
        si_o = ~si_o; // Released line shows no stale level
        #1000;
    endtask
endmodule
`default_nettype wire

/* tb/fvc_cfg1_top_tb.sv */
`include "fvc_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module fvc_cfg1_top_tb;
    logic ref_clk_i = 1'b0;
    logic resetn_i, wp_n_i, io3_rst_n_i, suspended_i, pin_gated_protect_i;
    logic [3:0] otp_lock_i;
    logic [7:0] nv_cfg1_i, nv_cfg2_i, cfg1_o, cfg2_o, d, rej_cnt;
    logic sck, csn, si, so_o, so_oe_n_o, width4_active_o, io2_data_sel_o;
    logic wp_n_eff_o, invert_map_o, hw_reset_o, write_reject_o, io3_data_sel_o, io3_seen;
    logic [39:0] rx;
    int error_cnt = 0;
    int total_checks = 0;

    fvc_cfg1_top i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sck_i(sck),
        .csn_i(csn), .si_i(si), .wp_n_i(wp_n_i), .io3_rst_n_i(io3_rst_n_i),
        .suspended_i(suspended_i), .otp_lock_i(otp_lock_i), .nv_cfg1_i(nv_cfg1_i),
        .nv_cfg2_i(nv_cfg2_i), .pin_gated_protect_i(pin_gated_protect_i), .so_o(so_o),
        .so_oe_n_o(so_oe_n_o), .cfg1_o(cfg1_o), .cfg2_o(cfg2_o),
        .width4_active_o(width4_active_o), .io2_data_sel_o(io2_data_sel_o),
        .io3_data_sel_o(io3_data_sel_o), .wp_n_eff_o(wp_n_eff_o), .invert_map_o(invert_map_o),
        .hw_reset_o(hw_reset_o), .write_reject_o(write_reject_o));

    fvc_host_model i_host (.so_i(so_o), .so_oe_n_i(so_oe_n_o), .sck_o(sck), .csn_o(csn),
        .si_o(si));

    // System clock
    always #50 ref_clk_i = ~ref_clk_i;

    // Count refused write commands, note shared pin used as data
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            rej_cnt <= 8'h00;
            io3_seen <= 1'b0;
        end else begin
            if (write_reject_o === 1'b1) begin
                rej_cnt <= rej_cnt + 8'h01;
            end
            if (io3_data_sel_o === 1'b1) begin
                io3_seen <= 1'b1;
            end
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] op);
        i_host.frame(8, {32'h0, op}, rx);
    endtask

    // Optional volatile enable, then status byte plus config one byte
    task automatic wr_regs(input logic en, input logic [7:0] v);
        if (en) cmd(`FVC_OP_VOL_WREN);
        i_host.frame(24, {16'h0, `FVC_OP_WRITE_REGS, 8'h00, v}, rx);
    endtask

    task automatic wr_any(input logic en, input logic [23:0] a, input logic [7:0] v);
        if (en) cmd(`FVC_OP_VOL_WREN);
        i_host.frame(40, {`FVC_OP_WRITE_ANY, a, v}, rx);
    endtask

    task automatic rd_any(input logic [23:0] a, output logic [7:0] v);
        i_host.frame(40, {`FVC_OP_READ_ANY, a, 8'h00}, rx);
        v = rx[7:0];
    endtask

    task automatic complete_run;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #3000000;
        error_cnt++;
        complete_run;
    end

    initial begin
        resetn_i = 1'b0;
        wp_n_i = 1'b0;
        io3_rst_n_i = 1'b1;
        suspended_i = 1'b0;
        pin_gated_protect_i = 1'b0;
        otp_lock_i = 4'hA;
        nv_cfg1_i = 8'h42;
        nv_cfg2_i = 8'hE0;
        step(10);
        resetn_i = 1'b1;
        step(20);
        // Defaults after power-on
        chk_byte(cfg1_o, 8'h6A);
        chk_bit(width4_active_o, 1'b1);
        chk_bit(io2_data_sel_o, 1'b1);
        chk_bit(wp_n_eff_o, 1'b1);
        chk_bit(invert_map_o, 1'b1);
        chk_byte(cfg2_o, 8'hE0);
        i_host.frame(16, {24'h0, `FVC_OP_READ_CFG1, 8'h00}, rx);
        chk_byte(rx[7:0], 8'h6A);
        chk_bit(io3_seen, 1'b1);
        chk_bit(io3_data_sel_o, 1'b0);
        // Status inputs tracked
        suspended_i = 1'b1;
        otp_lock_i = 4'h5;
        step(5);
        chk_byte(cfg1_o, 8'hD6);
        // Write without enable refused
        wr_regs(1'b0, 8'h00);
        chk_byte(cfg1_o, 8'hD6);
        // Read-only bits hold, width switch lags
        wr_regs(1'b1, 8'hBC);
        chk_byte(cfg1_o, 8'h94);
        chk_bit(width4_active_o, 1'b1);
        step(10);
        chk_bit(width4_active_o, 1'b0);
        chk_bit(wp_n_eff_o, 1'b0);
        chk_bit(io2_data_sel_o, 1'b0);
        chk_bit(invert_map_o, 1'b0);
        // Quad-instruction mode forces width four
        cmd(`FVC_OP_QI_ENTER);
        chk_bit(cfg2_o[3], 1'b1);
        chk_bit(width4_active_o, 1'b0);
        step(10);
        chk_bit(width4_active_o, 1'b1);
        chk_bit(cfg1_o[1], 1'b0);
        rd_any(`FVC_A_CFG2_V, d);
        chk_byte(d, 8'hE8);
        cmd(`FVC_OP_QI_EXIT);
        step(10);
        chk_bit(width4_active_o, 1'b0);
        rd_any(`FVC_A_CFG1_NV, d);
        chk_byte(d, 8'h42);
        rd_any(24'h000010, d);
        chk_byte(d, 8'h00);
        // Pin-gated protect with write-protect low refuses
        pin_gated_protect_i = 1'b1;
        wr_any(1'b1, `FVC_A_CFG1_V, 8'h42);
        chk_byte(cfg1_o, 8'h94);
        wp_n_i = 1'b1;
        wr_any(1'b1, `FVC_A_CFG1_V, 8'h42);
        chk_byte(cfg1_o, 8'hD6);
        // Lock set together with other bits, then sticky
        wr_regs(1'b1, 8'h43);
        chk_byte(cfg1_o, 8'hD7);
        wr_regs(1'b1, 8'h00);
        chk_byte(cfg1_o, 8'hD7);
        wr_any(1'b1, `FVC_A_CFG2_V, 8'h00);
        chk_byte(cfg2_o, 8'hE0);
        // Soft reset keeps the lock
        nv_cfg1_i = 8'h00;
        cmd(`FVC_OP_SOFT_RESET);
        chk_byte(cfg1_o, 8'h95);
        // Hardware reset on the shared pin clears the lock
        io3_rst_n_i = 1'b0;
        step(6);
        chk_bit(hw_reset_o, 1'b1);
        io3_rst_n_i = 1'b1;
        step(6);
        chk_bit(hw_reset_o, 1'b0);
        chk_byte(cfg1_o, 8'h94);
        chk_byte(rej_cnt, 8'h04);
        // Unlocked write-any reaches config two
        wr_any(1'b1, `FVC_A_CFG2_V, 8'h88);
        chk_byte(cfg2_o, 8'h88);
        // Second power-on loads the lock default
        nv_cfg1_i = 8'h01;
        suspended_i = 1'b0;
        resetn_i = 1'b0;
        step(3);
        resetn_i = 1'b1;
        step(20);
        chk_byte(cfg1_o, 8'h15);
        complete_run;
    end
endmodule
`default_nettype wire
